/* File: logic/udcc_config_control.v */
// Purpose: device-wide configuration and control of a usb device core
// Assumes: protocol engine strobes on core_clk; phy pins asynchronous
// Notes:   register read data appear one cycle after the read strobe
// How it works
// - writing one to bit 31 resets whole controller; reads zero
// - dma machine held in reset while bit 29 is one
// - set descriptor stalls when support bit zero, else forwarded
// - with reconfig enabled, status in of set config/interface gets nak
// - clear endpoint halt on endpoint 0: ack if bit zero, else stall
// - hs turnaround timeout counts phy clocks, 736 up to 848 bit times
// - fs turnaround timeout counts phy clocks, 16 up to 18 bit times
// - rx valid or active held 2 ms with detection on flags phy error
// - two-bit policy field steers status-out data handling
// - internal decode: data gets stall at 01/11, empty gets ack at 0x/11
// - read-only width bit: zero 8-bit, one 16-bit phy path
// - config bits report sync frame, self powered, remote wakeup
// - speed field 00 high, 01 full, 10 low, 11 full
// - in slave-only mode, access to read confirm register completes zero-length out read
// - reconfig complete write lets pending request be acked; reads zero
// - control mode bit: one dma operation, zero slave only
`timescale 1ns/1ps
`include "udcc_defines.vh"
module udcc_config_control #(
  parameter NUM_OUT_EP   = 5,
  parameter PHY_WIDE     = 1,
  parameter STUCK_CYCLES = `UDCC_STUCK_TIME_US * `UDCC_CLK_MHZ
) (
  input  wire                  core_clk,
  input  wire                  srst,
  input  wire [11:0]           regAddr,
  input  wire [31:0]           regWdata,
  input  wire                  regWrite,
  input  wire                  regRead,
  output reg  [31:0]           regRdata,
  input  wire                  phyClk,
  input  wire                  phyRxValid,
  input  wire                  phyRxActive,
  input  wire                  setDescReq,
  input  wire                  ep0HaltClearReq,
  input  wire                  cfgStatusIn,
  input  wire                  statusOutPkt,
  input  wire                  statusOutEmpty,
  input  wire                  setupInternal,
  input  wire                  turnStart,
  input  wire                  turnEnd,
  output reg                   respValid,
  output reg  [1:0]            respCode,
  output reg                   respForward,
  output reg                   turnTimeout,
  output reg                   softResetPulse,
  output wire                  coreReset,
  output wire                  dmaReset,
  output wire                  dmaMode,
  output wire                  highSpeed,
  output wire                  lowSpeed,
  output wire                  syncFrameCap,
  output wire                  selfPowered,
  output wire                  remoteWakeCap,
  output wire                  phyWide,
  output reg                   phyError,
  output reg  [NUM_OUT_EP-1:0] zeroLenReadDone
);
  // read confirm registers sit on a fixed stride from the first one
  function is_confirm;
    input [11:0] addr;
    input [11:0] ep;
    begin
      is_confirm = (addr == `UDCC_OFS_RD_CONFIRM_BASE +
                    ep * `UDCC_OFS_RD_CONFIRM_STEP);
    end
  endfunction
  reg  [31:0] devConfig;
  reg         ctlDmaMode;
  reg         recfgDone;
  reg  [2:0]  phySync0;
  reg  [2:0]  phySync1;
  reg         phyClkLast;
  reg  [6:0]  turnCount;
  reg         turnActive;
  reg  [31:0] next_rdata;
  reg  [1:0]  next_code;
  reg         next_fwd;
  reg         next_valid;
  wire        wrConfig;
  wire        wrControl;
  wire        wrStatus;
  wire [1:0]  stuckHit;
  wire [2:0]  hsTrim;
  wire [2:0]  fsTrim;
  wire [1:0]  policy;
  wire [6:0]  turnLimit;
  wire        phyClkRise;
  assign wrConfig  = regWrite && (regAddr == `UDCC_OFS_DEV_CONFIG);
  assign wrControl = regWrite && (regAddr == `UDCC_OFS_DEV_CONTROL);
  assign wrStatus  = regWrite && (regAddr == `UDCC_OFS_BLOCK_STATUS);
  // soft reset only depends on srst so it can never latch itself on
  always @(posedge core_clk)
  begin
    if (srst)
      softResetPulse <= 1'b0;
    else
      softResetPulse <= wrConfig && regWdata[`UDCC_CFG_SOFT_RST];
  end
  assign coreReset = srst | softResetPulse;
  // device configuration register
  always @(posedge core_clk)
  begin
    if (coreReset)
      devConfig <= `UDCC_CFG_RESET;
    else if (wrConfig)
    begin
      devConfig[`UDCC_CFG_SOFT_RST] <= 1'b0;
      devConfig[`UDCC_CFG_KEEP30]   <= regWdata[`UDCC_CFG_KEEP30];
      devConfig[`UDCC_CFG_DMA_RST]  <= regWdata[`UDCC_CFG_DMA_RST];
      devConfig[28:19]              <= 10'h000;
      devConfig[18:7]               <= regWdata[18:7];
      devConfig[6]                  <= 1'b0;
      devConfig[`UDCC_CFG_PHY_WIDTH] <= 1'b1;
      devConfig[4:0]                <= regWdata[4:0];
    end
  end
  assign dmaReset      = devConfig[`UDCC_CFG_DMA_RST];
  assign hsTrim        = devConfig[`UDCC_CFG_HS_TRIM_HI:`UDCC_CFG_HS_TRIM_LO];
  assign fsTrim        = devConfig[`UDCC_CFG_FS_TRIM_HI:`UDCC_CFG_FS_TRIM_LO];
  assign policy        = devConfig[`UDCC_CFG_STAT_HI:`UDCC_CFG_STAT_LO];
  assign syncFrameCap  = devConfig[`UDCC_CFG_SYNC_FRAME];
  assign selfPowered   = devConfig[`UDCC_CFG_SELF_PWR];
  assign remoteWakeCap = devConfig[`UDCC_CFG_REMOTE_WAKE];
  assign phyWide       = (PHY_WIDE != 0);
  // 01 and 11 both decode to full speed
  assign highSpeed = devConfig[1:0] == `UDCC_SPD_HIGH;
  assign lowSpeed  = devConfig[1:0] == `UDCC_SPD_LOW;
  // device control: mode bit stored, reconfig complete is a write event
  always @(posedge core_clk)
  begin
    if (coreReset)
      ctlDmaMode <= 1'b0;
    else if (wrControl)
      ctlDmaMode <= regWdata[`UDCC_CTL_DMA_MODE];
  end
  assign dmaMode = ctlDmaMode;
  // read confirm strobes count only in slave-only operation
  genvar ep;
  generate
    for (ep = 0; ep < NUM_OUT_EP; ep = ep + 1)
    begin : g_confirm
      always @(posedge core_clk)
      begin
        if (coreReset)
          zeroLenReadDone[ep] <= 1'b0;
        else
          zeroLenReadDone[ep] <= (regWrite || regRead) && !ctlDmaMode &&
                                 is_confirm(regAddr, ep);
      end
    end
  endgenerate
  // register read path, one cycle latency
  always @*
  begin
    next_rdata = 32'h00000000;
    if (regAddr == `UDCC_OFS_DEV_CONFIG)
    begin
      next_rdata = devConfig;
      next_rdata[`UDCC_CFG_SOFT_RST]  = 1'b0;
      next_rdata[`UDCC_CFG_PHY_WIDTH] = phyWide;
    end
    else if (regAddr == `UDCC_OFS_DEV_CONTROL)
    begin
      // reconfig complete always reads zero
      next_rdata[`UDCC_CTL_DMA_MODE] = ctlDmaMode;
    end
    else if (regAddr == `UDCC_OFS_BLOCK_STATUS)
      next_rdata[`UDCC_STS_PHY_ERROR] = phyError;
  end
  always @(posedge core_clk)
  begin
    if (coreReset)
      regRdata <= 32'h00000000;
    else if (regRead)
      regRdata <= next_rdata;
    else
      regRdata <= 32'h00000000;
  end
  // phy pins: two flops before any logic looks at them
  always @(posedge core_clk)
  begin
    if (coreReset)
    begin
      phySync0   <= 3'h0;
      phySync1   <= 3'h0;
      phyClkLast <= 1'b0;
    end
    else
    begin
      phySync0   <= {phyClk, phyRxActive, phyRxValid};
      phySync1   <= phySync0;
      phyClkLast <= phySync1[2];
    end
  end
  assign phyClkRise = phySync1[2] && !phyClkLast;
  // stuck receive detection, one detector per phy receive signal
  genvar sg;
  generate
    for (sg = 0; sg < 2; sg = sg + 1)
    begin : g_stuck
      udcc_stuck_detect #(
        .CYCLES (STUCK_CYCLES),
        .CW     (32)
      ) u_stuck (
        .clk    (core_clk),
        .rst    (coreReset),
        .enable (devConfig[`UDCC_CFG_PHY_FAULT]),
        .level  (phySync1[sg]),
        .stuck  (stuckHit[sg])
      );
    end
  endgenerate
  // sticky phy error; a new hit wins over a write-one clear
  always @(posedge core_clk)
  begin
    if (coreReset)
      phyError <= 1'b0;
    else if (|stuckHit)
      phyError <= 1'b1;
    else if (wrStatus && regWdata[`UDCC_STS_PHY_ERROR])
      phyError <= 1'b0;
  end
  // turnaround limit in phy clocks; low speed shares the fs limit
  assign turnLimit = highSpeed ?
    (`UDCC_HS_LIMIT_BASE + {3'h0, hsTrim, 1'b0}) :
    (`UDCC_FS_LIMIT_BASE + {4'h0, fsTrim} +
     {5'h00, fsTrim[2:1]});
  always @(posedge core_clk)
  begin
    if (coreReset)
    begin
      turnActive  <= 1'b0;
      turnCount   <= 7'h00;
      turnTimeout <= 1'b0;
    end
    else
    begin
      turnTimeout <= 1'b0;
      if (turnStart)
      begin
        turnActive <= 1'b1;
        turnCount  <= 7'h00;
      end
      else if (turnEnd)
        turnActive <= 1'b0;
      else if (turnActive && phyClkRise)
      begin
        if (turnCount + 7'h01 >= turnLimit)
        begin
          turnTimeout <= 1'b1;
          turnActive  <= 1'b0;
        end
        else
          turnCount <= turnCount + 7'h01;
      end
    end
  end
  // handshake decision; one request per cycle, earlier checks win
  always @*
  begin
    next_valid = 1'b1;
    next_code  = `UDCC_HS_DEFER;
    next_fwd   = 1'b0;
    if (setDescReq)
    begin
      if (devConfig[`UDCC_CFG_SET_DESC])
        next_fwd = 1'b1;
      else
        next_code = `UDCC_HS_STALL;
    end
    else if (ep0HaltClearReq)
      next_code = devConfig[`UDCC_CFG_HALT_RESP] ?
                  `UDCC_HS_STALL : `UDCC_HS_ACK;
    else if (cfgStatusIn)
      next_code = (devConfig[`UDCC_CFG_RECFG_EN] && !recfgDone) ?
                  `UDCC_HS_NAK : `UDCC_HS_ACK;
    else if (statusOutPkt)
    begin
      // reserved policy 10 falls back to the endpoint's own control
      next_fwd = 1'b1;
      if (statusOutEmpty)
      begin
        if (setupInternal && policy != 2'h2)
        begin
          next_code = `UDCC_HS_ACK;
          next_fwd  = 1'b0;
        end
      end
      else if (policy == 2'h3)
      begin
        next_code = `UDCC_HS_STALL;
        next_fwd  = 1'b0;
      end
      else if (setupInternal && policy == 2'h1)
        next_code = `UDCC_HS_STALL;
    end
    else
      next_valid = 1'b0;
  end
  always @(posedge core_clk)
  begin
    if (coreReset)
    begin
      respValid   <= 1'b0;
      respCode    <= `UDCC_HS_DEFER;
      respForward <= 1'b0;
    end
    else
    begin
      respValid   <= next_valid;
      respCode    <= next_code;
      respForward <= next_fwd;
    end
  end
  // completion flag: an ack given to status in consumes it, a fresh
  // write in the same cycle wins
  always @(posedge core_clk)
  begin
    if (coreReset)
      recfgDone <= 1'b0;
    else if (wrControl && regWdata[`UDCC_CTL_RECFG_DONE])
      recfgDone <= 1'b1;
    else if (cfgStatusIn && !setDescReq && !ep0HaltClearReq &&
             next_code == `UDCC_HS_ACK)
      recfgDone <= 1'b0;
  end
endmodule // udcc_config_control

/* File: logic/udcc_defines.vh */
// Purpose: shared constants of the usb device configuration block
// Assumes: 32-bit register port, byte offsets
// Notes:   definitions only
`ifndef UDCC_DEFINES_VH
`define UDCC_DEFINES_VH

// register byte offsets
`define UDCC_OFS_DEV_CONFIG      12'h400
`define UDCC_OFS_DEV_CONTROL     12'h404
`define UDCC_OFS_BLOCK_STATUS    12'h408
`define UDCC_OFS_RD_CONFIRM_BASE 12'h21c
`define UDCC_OFS_RD_CONFIRM_STEP 12'h020

// device configuration fields
`define UDCC_CFG_RESET       32'h00000020
`define UDCC_CFG_SOFT_RST    31
`define UDCC_CFG_KEEP30      30
`define UDCC_CFG_DMA_RST     29
`define UDCC_CFG_SET_DESC    18
`define UDCC_CFG_RECFG_EN    17
`define UDCC_CFG_HALT_RESP   16
`define UDCC_CFG_HS_TRIM_HI  15
`define UDCC_CFG_HS_TRIM_LO  13
`define UDCC_CFG_FS_TRIM_HI  12
`define UDCC_CFG_FS_TRIM_LO  10
`define UDCC_CFG_PHY_FAULT   9
`define UDCC_CFG_STAT_HI     8
`define UDCC_CFG_STAT_LO     7
`define UDCC_CFG_PHY_WIDTH   5
`define UDCC_CFG_SYNC_FRAME  4
`define UDCC_CFG_SELF_PWR    3
`define UDCC_CFG_REMOTE_WAKE 2
`define UDCC_CFG_SPEED_HI    1
`define UDCC_CFG_SPEED_LO    0

// device control fields
`define UDCC_CTL_RECFG_DONE  13
`define UDCC_CTL_DMA_MODE    9

// own status register fields
`define UDCC_STS_PHY_ERROR   0

// handshake codes; defer means the endpoint control decides
`define UDCC_HS_ACK          2'h0
`define UDCC_HS_NAK          2'h1
`define UDCC_HS_STALL        2'h2
`define UDCC_HS_DEFER        2'h3

// speed codes
`define UDCC_SPD_HIGH        2'h0
`define UDCC_SPD_FULL        2'h1
`define UDCC_SPD_LOW         2'h2
`define UDCC_SPD_FULL_ALT    2'h3

// timing
`define UDCC_CLK_MHZ         100
`define UDCC_STUCK_TIME_US   2000
// turnaround limits in phy clocks: hs 8 bits per clock, fs 5 clocks per bit
`define UDCC_HS_LIMIT_BASE   7'h5c
`define UDCC_FS_LIMIT_BASE   7'h50

`endif

/* File: logic/udcc_stuck_detect.v */
// Purpose: flags a level held high without a break for a set time
// Assumes: level already synchronised to clk
// Notes:   one pulse per unbroken stretch
`timescale 1ns/1ps
module udcc_stuck_detect #(
  parameter CYCLES = 200000,
  parameter CW     = 18
) (
  input  wire clk,
  input  wire rst,
  input  wire enable,
  input  wire level,
  output reg  stuck
);
  reg [CW-1:0] count;
  reg          fired;

  always @(posedge clk)
  begin
    if (rst)
    begin
      count <= {CW{1'b0}};
      fired <= 1'b0;
      stuck <= 1'b0;
    end
    else
    begin
      stuck <= 1'b0;
      // any break in the level, or disabling, restarts the measurement
      if (!enable || !level)
      begin
        count <= {CW{1'b0}};
        fired <= 1'b0;
      end
      else if (!fired)
      begin
        if (count == CYCLES[CW-1:0] - {{(CW-1){1'b0}}, 1'b1})
        begin
          stuck <= 1'b1;
          fired <= 1'b1;
        end
        else
          count <= count + {{(CW-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule // udcc_stuck_detect

/* File: tb/udcc_config_control_asserts.sv */
// Purpose: concurrent checks on the configuration block ports
// Assumes: one core_clk domain, srst synchronous active high
// Notes:   bound to every instance of the block
`timescale 1ns/1ps
`include "udcc_defines.vh"
module udcc_config_control_asserts #(
  parameter NUM_OUT_EP = 5
) (
  input wire                  core_clk,
  input wire                  srst,
  input wire [11:0]           regAddr,
  input wire [31:0]           regWdata,
  input wire                  regWrite,
  input wire                  regRead,
  input wire [31:0]           regRdata,
  input wire                  setDescReq,
  input wire                  ep0HaltClearReq,
  input wire                  cfgStatusIn,
  input wire                  statusOutPkt,
  input wire                  respValid,
  input wire                  turnTimeout,
  input wire                  softResetPulse,
  input wire                  coreReset,
  input wire                  dmaReset,
  input wire                  dmaMode,
  input wire                  highSpeed,
  input wire                  lowSpeed,
  input wire                  phyWide,
  input wire                  phyError,
  input wire [NUM_OUT_EP-1:0] zeroLenReadDone
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  wire cfgWr  = regWrite && regAddr == `UDCC_OFS_DEV_CONFIG;
  wire anyReq = setDescReq | ep0HaltClearReq | cfgStatusIn | statusOutPkt;
  wire errClr = regWrite && regAddr == `UDCC_OFS_BLOCK_STATUS && regWdata[0];

  a_soft_pulse: assert property (
    cfgWr && regWdata[31] && !softResetPulse
    |=> softResetPulse ##1 !softResetPulse) else $error("soft reset pulse");
  a_soft_core: assert property (
    softResetPulse |-> coreReset ##1 (!dmaReset && !dmaMode && !phyError
    && highSpeed && !lowSpeed && !respValid && !zeroLenReadDone))
    else $error("soft reset incomplete");
  a_dma_level: assert property (
    cfgWr && !regWdata[31] && !softResetPulse
    |=> dmaReset == $past(regWdata[29])) else $error("dma reset level");
  a_resp_time: assert property (
    anyReq && !coreReset |=> respValid) else $error("response late");
  a_resp_cause: assert property (
    respValid |-> $past(anyReq)) else $error("response without request");
  a_cfg_read: assert property (
    regRead && regAddr == `UDCC_OFS_DEV_CONFIG && !softResetPulse
    |=> !regRdata[31] && !regRdata[6] && regRdata[5] == phyWide)
    else $error("config read bits");
  a_done_zero: assert property (
    regRead && regAddr == `UDCC_OFS_DEV_CONTROL |=> !regRdata[13])
    else $error("done bit reads one");
  a_speed_excl: assert property (
    !(highSpeed && lowSpeed)) else $error("speed decode clash");
  a_confirm_slave: assert property (
    |zeroLenReadDone |-> $onehot(zeroLenReadDone)
    && $past(!dmaMode && (regRead || regWrite))) else $error("confirm pulse");
  a_err_sticky: assert property (
    phyError && !coreReset && !errClr |=> phyError)
    else $error("phy error dropped");
  a_timeout_pulse: assert property (
    turnTimeout |=> !turnTimeout) else $error("timeout not a pulse");
endmodule // udcc_config_control_asserts

bind udcc_config_control udcc_config_control_asserts
  #(.NUM_OUT_EP(NUM_OUT_EP)) u_chk (.*);

/* File: tb/udcc_config_control_bench.sv */
// Purpose: self-checking bench of the configuration block
// Assumes: stuck time shortened to 50 cycles
// Notes:   fixed xorshift seed keeps runs repeatable
`timescale 1ns/1ps
`include "udcc_defines.vh"
module udcc_config_control_bench;
  logic core_clk, srst, regWrite, regRead, phyClk, phyRxValid, phyRxActive;
  logic setDescReq, ep0HaltClearReq, cfgStatusIn, statusOutPkt, turnEnd;
  logic statusOutEmpty, setupInternal, turnStart, frame, hold, respValid;
  logic respForward, turnTimeout, softResetPulse, coreReset, dmaReset;
  logic dmaMode, highSpeed, lowSpeed, syncFrameCap, selfPowered, phyWide;
  logic remoteWakeCap, phyError;
  logic [11:0] regAddr;
  logic [31:0] regWdata, regRdata, d, w, c, seed;
  logic [1:0]  respCode;
  logic [2:0]  e;
  logic [4:0]  zeroLenReadDone, zl;
  int          errors, comparisons, n, lim;

  udcc_config_control #(.STUCK_CYCLES(50)) dut (.*);
  udcc_phy_model phy (.*);

  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  function automatic [31:0] xs(input [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  // {forward, code} for a status-out packet
  function automatic [2:0] sofn(input [1:0] p, input i, input z);
    if (i && z && p != 2'h2) return {1'b0, `UDCC_HS_ACK};
    if (p == 2'h3 && !z) return {1'b0, `UDCC_HS_STALL};
    if (i && p == 2'h1 && !z) return {1'b1, `UDCC_HS_STALL};
    return {1'b1, `UDCC_HS_DEFER};
  endfunction

  task automatic print_verdict;
    if (errors == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    comparisons++;
    if (s !== x)
    begin
      errors++;
      $display("Error %s expected %h seen %h", nm, x, s);
    end
  endtask

  task automatic wr(input [11:0] a, input [31:0] v);
    @(posedge core_clk);
    regAddr  <= a;
    regWdata <= v;
    regWrite <= 1'b1;
    @(posedge core_clk);
    regWrite <= 1'b0;
  endtask

  task automatic rd(input [11:0] a);
    @(posedge core_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge core_clk);
    regRead <= 1'b0;
    #1;
    d  = regRdata;
    zl = zeroLenReadDone;
  endtask

  task automatic hs(input [3:0] r, input [1:0] x);
    @(posedge core_clk);
    {setDescReq, ep0HaltClearReq, cfgStatusIn, statusOutPkt} <= r;
    @(posedge core_clk);
    {setDescReq, ep0HaltClearReq, cfgStatusIn, statusOutPkt} <= 4'h0;
    #1;
    chk("response", {respValid, respCode}, {1'b1, x});
  endtask

  task automatic turn(input [2:0] t, input [1:0] sp);
    logic p;
    wr(`UDCC_OFS_DEV_CONFIG, {16'h0, t, t, 8'h0, sp});
    lim = (sp == 2'h0) ? 92 + 2 * t : 80 + t + t / 2;
    frame <= 1'b1;
    @(posedge core_clk);
    turnStart <= 1'b1;
    @(posedge core_clk);
    turnStart <= 1'b0;
    n = 0;
    p = phyClk;
    for (int k = 0; k < 1500 && turnTimeout !== 1'b1; k++)
    begin
      @(posedge core_clk);
      #1;
      if (phyClk && !p) n++;
      p = phyClk;
    end
    frame <= 1'b0;
    if (turnTimeout !== 1'b1)
    begin
      errors++;
      print_verdict;
    end
    chk("turnaround", n >= lim - 1 && n <= lim + 1, 1);
  endtask

  initial
  begin
    {regWrite, regRead, setDescReq, ep0HaltClearReq, cfgStatusIn} = '0;
    {statusOutPkt, statusOutEmpty, setupInternal, turnStart} = '0;
    {turnEnd, frame, hold} = '0;
    {regAddr, regWdata} = '0;
    seed = 32'h72be55bd;
    srst = 1'b1;
    repeat (10) @(posedge core_clk);
    srst <= 1'b0;
    rd(`UDCC_OFS_DEV_CONFIG);
    chk("config reset", d, `UDCC_CFG_RESET);
    for (int i = 0; i < 8; i++)
    begin
      seed = xs(seed);
      // bit 30 written back as last read; phy fault enable bit 9 kept off here
      w = (seed & 32'h3fff_fdfc) | (d & 32'h4000_0000) | i[1:0];
      wr(`UDCC_OFS_DEV_CONFIG, w);
      rd(`UDCC_OFS_DEV_CONFIG);
      chk("config", d, (w & 32'h6007_ff9f) | 32'h20);
      chk("flags", {dmaReset, syncFrameCap, selfPowered, remoteWakeCap,
        highSpeed, lowSpeed, phyWide}, {w[29], w[4:2], w[1:0] == 2'h0,
        w[1:0] == 2'h2, 1'b1});
    end
    wr(`UDCC_OFS_DEV_CONFIG, 32'h8000_0000);
    rd(`UDCC_OFS_DEV_CONFIG);
    chk("after soft reset", d, `UDCC_CFG_RESET);
    for (int i = 0; i < 32; i++)
    begin
      seed = xs(seed);
      c = seed;
      wr(`UDCC_OFS_DEV_CONFIG, c & 32'h0005_0180);
      setupInternal  <= c[0];
      statusOutEmpty <= c[1];
      hs({1'b1, c[2], 1'b0, c[3]},
        c[18] ? `UDCC_HS_DEFER : `UDCC_HS_STALL);
      hs({2'b01, c[4], c[5]}, c[16] ? `UDCC_HS_STALL : `UDCC_HS_ACK);
      e = sofn(c[8:7], c[0], c[1]);
      hs(4'h1, e[1:0]);
      chk("forward", respForward, e[2]);
    end
    hs(4'h2, `UDCC_HS_ACK);
    wr(`UDCC_OFS_DEV_CONFIG, 32'h0002_0000);
    hs(4'h2, `UDCC_HS_NAK);
    hs(4'h2, `UDCC_HS_NAK);
    wr(`UDCC_OFS_DEV_CONTROL, 32'h0000_2000);
    hs(4'h2, `UDCC_HS_ACK);
    hs(4'h2, `UDCC_HS_NAK);
    wr(`UDCC_OFS_DEV_CONTROL, 32'h0);
    for (int i = 0; i < 6; i++)
    begin
      rd(`UDCC_OFS_RD_CONFIRM_BASE + i * `UDCC_OFS_RD_CONFIRM_STEP);
      chk("confirm", zl, (i < 5) ? 5'h1 << i : 5'h0);
    end
    wr(`UDCC_OFS_DEV_CONTROL, 32'h0000_0200);
    rd(`UDCC_OFS_RD_CONFIRM_BASE);
    chk("dma mode", {dmaMode, zl}, 6'h20);
    rd(12'h7f0);
    chk("unmapped", d, 32'h0);
    turn(3'h7, 2'h0);
    turn(3'h0, 2'h0);
    turn(seed[2:0], 2'h1);
    turn(3'h7, 2'h2);
    // a wait ended early must never time out
    @(posedge core_clk);
    frame     <= 1'b1;
    turnStart <= 1'b1;
    @(posedge core_clk);
    turnStart <= 1'b0;
    repeat (200) @(posedge core_clk);
    turnEnd <= 1'b1;
    @(posedge core_clk);
    turnEnd <= 1'b0;
    n = 0;
    repeat (900)
    begin
      @(posedge core_clk);
      #1;
      if (turnTimeout !== 1'b0) n++;
    end
    frame <= 1'b0;
    chk("turn end", n, 0);
    wr(`UDCC_OFS_DEV_CONFIG, 32'h0000_0200);
    for (int i = 0; i < 2; i++)
    begin
      hold <= 1'b1;
      repeat (40) @(posedge core_clk);
      hold <= 1'b0;
      repeat (4) @(posedge core_clk);
    end
    #1;
    chk("short stuck", phyError, 1'b0);
    hold <= 1'b1;
    repeat (60) @(posedge core_clk);
    hold <= 1'b0;
    rd(`UDCC_OFS_BLOCK_STATUS);
    chk("phy error", {phyError, d[0]}, 2'h3);
    wr(`UDCC_OFS_BLOCK_STATUS, 32'h1);
    rd(`UDCC_OFS_BLOCK_STATUS);
    chk("phy error clear", {phyError, d[0]}, 2'h0);
    print_verdict;
  end
endmodule // udcc_config_control_bench

/* File: tb/udcc_phy_model.sv */
// Purpose: transceiver side as seen by the configuration block
// Assumes: phy clock of 80 ns, running only inside frames
// Notes:   hold models a receiver stuck in the active state
`timescale 1ns/1ps
module udcc_phy_model (
  input  wire logic frame,
  input  wire logic hold,
  output logic      phyClk,
  output logic      phyRxValid,
  output logic      phyRxActive
);
  // clock stands low between frames so turnaround counts only in frames
  initial
  begin
    phyClk = 1'b0;
    forever #40 phyClk = frame ? ~phyClk : 1'b0;
  end
  assign phyRxValid  = hold;
  assign phyRxActive = hold;
endmodule // udcc_phy_model
